/* fmd_defines.vh */
// Shared constants for the FIR multiply-add datapath
`ifndef FMD_DEFINES_VH
`define FMD_DEFINES_VH

// Data path widths
`define FMD_SAMPLE_W 18
`define FMD_COEF_W 18
`define FMD_SLICE_OUT_W 38
`define FMD_NARROW_W 9
`define FMD_TAPS 8
`define FMD_SLICE_TAPS 4

// Register byte offsets
`define FMD_OFS_CTRL 8'h00
`define FMD_OFS_STATUS 8'h04
`define FMD_OFS_RESULT_LO 8'h08
`define FMD_OFS_RESULT_HI 8'h0c
`define FMD_OFS_COEF_BASE 8'h20
`define FMD_COEF_PAGE 3'b001

// Control register fields
`define FMD_CTRL_SERIAL 0
`define FMD_CTRL_TDM 1
`define FMD_CTRL_IN_REG 2
`define FMD_CTRL_PIPE_REG 3
`define FMD_CTRL_OUT_REG 4
`define FMD_CTRL_NARROW 5
`define FMD_CTRL_W 6
`define FMD_CTRL_RESET 6'h1d

// Status register fields
`define FMD_STAT_RUN 0
`define FMD_STAT_CNT_LSB 16
`define FMD_CNT_W 16

// Delay of the stage-tag chain (one per optional register stage)
`define FMD_TAG_DEPTH 3

`endif

/* fmd_mac_slice.v */
// Four-multiplier adder slice with chained input registers
`timescale 1ns/1ps
`include "fmd_defines.vh"

module fmd_mac_slice #(
  parameter DW = `FMD_SAMPLE_W,
  parameter CW = `FMD_COEF_W,
  parameter OW = `FMD_SLICE_OUT_W
) (
  input wire core_clk,
  input wire reset,
  input wire load_en,
  input wire chain_sel,
  input wire in_reg_en,
  input wire pipe_en,
  input wire out_reg_en,
  input wire [DW-1:0] shift_in,
  input wire [4*DW-1:0] par_x,
  input wire [4*CW-1:0] coef,
  output wire [DW-1:0] shift_out,
  output wire [OW-1:0] sum_out
);

  localparam PW = DW + CW;

  reg [4*DW-1:0] x_reg;
  reg [4*PW-1:0] prod_reg;
  reg [OW-1:0] sum_reg;
  wire [4*DW-1:0] x_next;
  wire [4*DW-1:0] mul_x;
  wire [4*PW-1:0] prod;
  wire [4*PW-1:0] prod_use;
  wire signed [OW-1:0] sum_c;

  // Per-tap load selector, chain register and multiplier
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_tap
      if (i == 0) begin : g_head
        assign x_next[DW-1:0] = chain_sel ? shift_in : par_x[DW-1:0];
      end else begin : g_body
        assign x_next[i*DW +: DW] = chain_sel ? x_reg[(i-1)*DW +: DW]
                                              : par_x[i*DW +: DW];
      end
      // Chain always uses the registers; parallel may bypass them
      assign mul_x[i*DW +: DW] = (chain_sel | in_reg_en) ?
                                 x_reg[i*DW +: DW] : par_x[i*DW +: DW];
      assign prod[i*PW +: PW] = $signed(mul_x[i*DW +: DW]) *
                                $signed(coef[i*CW +: CW]);
    end
  endgenerate

  // Input taps shift on the sample strobe only
  always @(posedge core_clk) begin
    if (reset) begin
      x_reg <= {4*DW{1'b0}};
    end else if (load_en) begin
      x_reg <= x_next;
    end
  end

  // Optional pipeline and output stages run every cycle
  always @(posedge core_clk) begin
    if (reset) begin
      prod_reg <= {4*PW{1'b0}};
      sum_reg <= {OW{1'b0}};
    end else begin
      prod_reg <= prod;
      sum_reg <= sum_c;
    end
  end

  assign prod_use = pipe_en ? prod_reg : prod;

  // Three adders; 38 bits keep four 36-bit products from overflowing
  assign sum_c = $signed(prod_use[0*PW +: PW]) +
                 $signed(prod_use[1*PW +: PW]) +
                 $signed(prod_use[2*PW +: PW]) +
                 $signed(prod_use[3*PW +: PW]);

  assign sum_out = out_reg_en ? sum_reg : sum_c;
  assign shift_out = x_reg[3*DW +: DW];

endmodule

/* fmd_coef_store.v */
// Coefficient store with a registered four-word bank read port
`timescale 1ns/1ps
`include "fmd_defines.vh"

module fmd_coef_store #(
  parameter CW = `FMD_COEF_W
) (
  input wire core_clk,
  input wire reset,
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [CW-1:0] wr_data,
  input wire bank_odd,
  output wire [8*CW-1:0] coef_all,
  output reg [4*CW-1:0] bank_out
);

  reg [CW-1:0] mem [0:7];
  integer k;
  integer j;

  // Writable at run time so the filter can adapt
  always @(posedge core_clk) begin
    if (reset) begin
      for (k = 0; k < 8; k = k + 1) begin
        mem[k] <= {CW{1'b0}};
      end
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Bank read runs on the fast clock, one cycle ahead of use
  always @(posedge core_clk) begin
    if (reset) begin
      bank_out <= {4*CW{1'b0}};
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        bank_out[j*CW +: CW] <= bank_odd ? mem[2*j+1] : mem[2*j];
      end
    end
  end

  // Flat view of all eight words for the dual-slice path and reads
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bank
      assign coef_all[i*CW +: CW] = mem[i];
      assign coef_all[(i+4)*CW +: CW] = mem[i+4];
    end
  endgenerate

endmodule

/* fmd_fir_top.v */
// FIR filter datapath: two cascaded slices, TDM mode and APB registers
`timescale 1ns/1ps
`include "fmd_defines.vh"

module fmd_fir_top #(
  parameter DW = `FMD_SAMPLE_W,
  parameter CW = `FMD_COEF_W,
  parameter OW = `FMD_SLICE_OUT_W
) (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [DW-1:0] sample_in,
  input wire sample_valid,
  output wire sample_ready,
  output reg [OW:0] result_out,
  output reg result_valid
);

  localparam YW = OW + 1;

  // Keep only the low nine bits, sign extended, in narrow mode
  function [DW-1:0] fmd_narrow;
    input [DW-1:0] val;
    input en;
    begin
      if (en) begin
        fmd_narrow = {{(DW-`FMD_NARROW_W){val[`FMD_NARROW_W-1]}},
                      val[`FMD_NARROW_W-1:0]};
      end else begin
        fmd_narrow = val;
      end
    end
  endfunction

  // Pick a stage tag delayed by k cycles (0 = undelayed)
  function fmd_tap;
    input tag0;
    input [`FMD_TAG_DEPTH-1:0] sr;
    input [1:0] k;
    begin
      case (k)
        2'd0: fmd_tap = tag0;
        2'd1: fmd_tap = sr[0];
        2'd2: fmd_tap = sr[1];
        2'd3: fmd_tap = sr[2];
        default: fmd_tap = tag0;
      endcase
    end
  endfunction

  reg [`FMD_CTRL_W-1:0] ctrl_reg;
  reg [8*DW-1:0] line_reg;
  reg phase_reg;
  reg run_reg;
  reg [`FMD_CNT_W-1:0] count_reg;
  reg [`FMD_TAG_DEPTH-1:0] vld_sr_reg;
  reg [`FMD_TAG_DEPTH-1:0] ph_sr_reg;
  reg [OW-1:0] hold_reg;

  wire mode_serial;
  wire mode_tdm;
  wire mode_narrow;
  wire in_used;
  wire [DW-1:0] sample_n;
  wire [8*DW-1:0] line_next;
  wire strobe;
  wire phase_next;
  wire [8*CW-1:0] coef_all;
  wire [4*CW-1:0] coef_bank;
  wire [4*DW-1:0] par_a;
  wire [4*DW-1:0] par_b;
  wire [4*DW-1:0] tdm_x;
  wire [4*CW-1:0] coef_a;
  wire [DW-1:0] chain_ab;
  wire [OW-1:0] sum_a;
  wire [OW-1:0] sum_b;
  wire [1:0] lat;
  wire tag_v0;
  wire tag_v;
  wire tag_ph;
  wire [YW-1:0] y_dual;
  wire [YW-1:0] y_tdm;
  wire apb_wr;
  wire apb_setup;
  wire coef_hit;

  assign mode_serial = ctrl_reg[`FMD_CTRL_SERIAL];
  assign mode_tdm = ctrl_reg[`FMD_CTRL_TDM];
  assign mode_narrow = ctrl_reg[`FMD_CTRL_NARROW];

  // Samples are cut to nine bits in narrow mode
  assign sample_n = fmd_narrow(sample_in, mode_narrow);

  // TDM takes one sample per two fast cycles, at the end of phase 1
  assign sample_ready = mode_tdm ? phase_reg : 1'b1;
  assign strobe = sample_valid & sample_ready;
  assign phase_next = mode_tdm ? ~phase_reg : 1'b0;

  // Phase divider: the sample rate is an enable on the single clock
  always @(posedge core_clk) begin
    if (reset) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // External delay line, newest sample in the lowest slot
  assign line_next = {line_reg[7*DW-1:0], sample_n};

  always @(posedge core_clk) begin
    if (reset) begin
      line_reg <= {8*DW{1'b0}};
    end else if (strobe) begin
      line_reg <= line_next;
    end
  end

  // Run flag and accepted sample count for status
  always @(posedge core_clk) begin
    if (reset) begin
      run_reg <= 1'b0;
      count_reg <= {`FMD_CNT_W{1'b0}};
    end else begin
      // A take in the same cycle as a control write keeps the flag set
      if (apb_wr && paddr == `FMD_OFS_CTRL) begin
        run_reg <= 1'b0;
      end
      if (strobe) begin
        run_reg <= 1'b1;
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // Coefficient store; bank for the coming phase is fetched one cycle early
  fmd_coef_store #(
    .CW(CW)
  ) u_coef (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(coef_hit),
    .wr_idx(paddr[4:2]),
    .wr_data(fmd_narrow(pwdata[CW-1:0], mode_narrow)),
    .bank_odd(~phase_next),
    .coef_all(coef_all),
    .bank_out(coef_bank)
  );

  // TDM pairs: phase 0 takes odd taps, phase 1 the even taps
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_tdm
      assign tdm_x[i*DW +: DW] = phase_reg ? line_reg[(2*i)*DW +: DW]
                                           : line_reg[(2*i+1)*DW +: DW];
    end
  endgenerate

  // Outside TDM, parallel loads take the line as it will stand after this sample; TDM reads the stored line
  assign par_a = mode_tdm ? tdm_x : line_next[4*DW-1:0];
  assign par_b = line_next[8*DW-1:4*DW];
  assign coef_a = mode_tdm ? coef_bank : coef_all[4*CW-1:0];

  // In TDM the slice inputs come straight from the outside delay line
  fmd_mac_slice #(
    .DW(DW),
    .CW(CW),
    .OW(OW)
  ) u_slice_a (
    .core_clk(core_clk),
    .reset(reset),
    .load_en(strobe),
    .chain_sel(mode_serial & ~mode_tdm),
    .in_reg_en(ctrl_reg[`FMD_CTRL_IN_REG] & ~mode_tdm),
    .pipe_en(ctrl_reg[`FMD_CTRL_PIPE_REG]),
    .out_reg_en(ctrl_reg[`FMD_CTRL_OUT_REG]),
    .shift_in(sample_n),
    .par_x(par_a),
    .coef(coef_a),
    .shift_out(chain_ab),
    .sum_out(sum_a)
  );

  // Second slice continues the chain from the first
  fmd_mac_slice #(
    .DW(DW),
    .CW(CW),
    .OW(OW)
  ) u_slice_b (
    .core_clk(core_clk),
    .reset(reset),
    .load_en(strobe),
    .chain_sel(mode_serial & ~mode_tdm),
    .in_reg_en(ctrl_reg[`FMD_CTRL_IN_REG] & ~mode_tdm),
    .pipe_en(ctrl_reg[`FMD_CTRL_PIPE_REG]),
    .out_reg_en(ctrl_reg[`FMD_CTRL_OUT_REG]),
    .shift_in(chain_ab),
    .par_x(par_b),
    .coef(coef_all[8*CW-1:4*CW]),
    .shift_out(),
    .sum_out(sum_b)
  );

  // Latency through the enabled stages; chaining always uses input regs
  assign in_used = (mode_serial | ctrl_reg[`FMD_CTRL_IN_REG]) & ~mode_tdm;
  assign lat = {1'b0, in_used} + {1'b0, ctrl_reg[`FMD_CTRL_PIPE_REG]} +
               {1'b0, ctrl_reg[`FMD_CTRL_OUT_REG]};

  // In TDM every fast cycle carries a partial once the line is primed
  assign tag_v0 = mode_tdm ? run_reg : strobe;

  // Tags follow the data through the optional stages
  always @(posedge core_clk) begin
    if (reset) begin
      vld_sr_reg <= {`FMD_TAG_DEPTH{1'b0}};
      ph_sr_reg <= {`FMD_TAG_DEPTH{1'b0}};
    end else begin
      vld_sr_reg <= {vld_sr_reg[`FMD_TAG_DEPTH-2:0], tag_v0};
      ph_sr_reg <= {ph_sr_reg[`FMD_TAG_DEPTH-2:0], phase_reg};
    end
  end

  assign tag_v = fmd_tap(tag_v0, vld_sr_reg, lat);
  assign tag_ph = fmd_tap(phase_reg, ph_sr_reg, lat);

  // External adder, one bit wider than its 38-bit operands
  assign y_dual = {sum_a[OW-1], sum_a} + {sum_b[OW-1], sum_b};
  assign y_tdm = {hold_reg[OW-1], hold_reg} + {sum_a[OW-1], sum_a};

  // Hold the first-phase partial outside the slice
  always @(posedge core_clk) begin
    if (reset) begin
      hold_reg <= {OW{1'b0}};
    end else if (mode_tdm && tag_v && !tag_ph) begin
      hold_reg <= sum_a;
    end
  end

  // Result register; factor two needs no accumulator, only the hold
  always @(posedge core_clk) begin
    if (reset) begin
      result_out <= {YW{1'b0}};
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (tag_v && (!mode_tdm || tag_ph)) begin
        result_out <= mode_tdm ? y_tdm : y_dual;
        result_valid <= 1'b1;
      end
    end
  end

  // APB slave, zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign coef_hit = apb_wr & (paddr[7:5] == `FMD_COEF_PAGE) &
                    (paddr[1:0] == 2'b00);

  // Control register steers mode and stage bypass
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= `FMD_CTRL_RESET;
    end else if (apb_wr && paddr == `FMD_OFS_CTRL) begin
      ctrl_reg <= pwdata[`FMD_CTRL_W-1:0];
    end
  end

  // Read mux and error flag; unmapped addresses read zero with error
  always @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr == `FMD_OFS_CTRL) begin
        prdata <= {{(32-`FMD_CTRL_W){1'b0}}, ctrl_reg};
      end else if (paddr == `FMD_OFS_STATUS) begin
        prdata <= {count_reg, 15'h0000, run_reg};
      end else if (paddr == `FMD_OFS_RESULT_LO) begin
        prdata <= result_out[31:0];
      end else if (paddr == `FMD_OFS_RESULT_HI) begin
        prdata <= {{(64-YW){result_out[YW-1]}}, result_out[YW-1:32]};
      end else if (paddr[7:5] == `FMD_COEF_PAGE && paddr[1:0] == 2'b00) begin
        prdata <= {{(32-CW){coef_all[paddr[4:2]*CW+CW-1]}},
                   coef_all[paddr[4:2]*CW +: CW]};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule

/* fmd_fir_top_assertions.sv */
// Port checker for the FIR datapath top
`timescale 1ns/1ps
module fmd_fir_top_assertions #(
  parameter DW = 18,
  parameter OW = 38
) (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [DW-1:0] sample_in,
  input wire sample_valid,
  input wire sample_ready,
  input wire [OW:0] result_out,
  input wire result_valid
);
  logic [5:0] ctl_reg;
  wire take = sample_valid && sample_ready;
  wire wr_ctl = psel && penable && pwrite && paddr == 8'h00;
  wire bad = paddr[1:0] != 2'b00 || (paddr > 8'h0c && paddr[7:5] != 3'b001);

  // Shadow of the mode word, so each check knows the configuration
  always @(posedge core_clk)
    if (reset)
      ctl_reg <= 6'h1d;
    else if (wr_ctl)
      ctl_reg <= pwdata[5:0];

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_bad_setup;
    psel && !penable && bad;
  endsequence
  sequence s_good_setup;
    psel && !penable && !bad;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_tdm_beat;
    !result_valid ##1 result_valid;
  endsequence

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (s_bad_setup ##1 s_access |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (s_good_setup ##1 s_access |-> !pslverr)
    else $error("error on mapped access");
  a_ready_full: assert property (
    !ctl_reg[1] |-> sample_ready)
    else $error("sample not accepted outside tdm");
  a_tdm_alternate: assert property (
    ctl_reg[1] && $past(ctl_reg[1]) |-> sample_ready != $past(sample_ready))
    else $error("tdm ready not alternating");
  a_lat_default: assert property (
    take && ctl_reg == 6'h1d |-> ##4 result_valid)
    else $error("default latency wrong");
  a_no_extra: assert property (
    result_valid && ctl_reg == 6'h1d && $past(ctl_reg, 4) == 6'h1d
    |-> $past(take, 4))
    else $error("result without sample");
  a_tdm_latency: assert property (
    take && ctl_reg == 6'h1f |-> ##5 result_valid)
    else $error("tdm latency wrong");
  a_tdm_rate: assert property (disable iff (reset || wr_ctl)
    ctl_reg[1] && !wr_ctl && result_valid |=> s_tdm_beat)
    else $error("tdm result rate wrong");
  a_hold_out: assert property (
    !result_valid |-> $stable(result_out))
    else $error("result changed without valid");
endmodule

bind fmd_fir_top fmd_fir_top_assertions #(.DW(DW), .OW(OW)) fmd_chk_inst (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
  .sample_valid(sample_valid), .sample_ready(sample_ready),
  .result_out(result_out), .result_valid(result_valid)
);

/* fmd_sample_src.sv */
// Upstream sample source model feeding the datapath
`timescale 1ns/1ps
module fmd_sample_src #(
  parameter DW = 18
) (
  input wire core_clk,
  input wire reset,
  input wire sample_ready,
  input wire slow,
  output logic [DW-1:0] sample_in,
  output logic sample_valid
);
  logic [DW-1:0] pend_q[$];

  // Samples queued here go out in order
  task automatic push(input logic [DW-1:0] x);
    pend_q.push_back(x);
  endtask

  initial begin
    sample_in = '0;
    sample_valid = 1'b0;
  end

  // Head held until taken; slow mode idles one cycle after each take.
  // Idle data is inverted so a stale word never passes for a sample.
  always @(posedge core_clk) begin
    logic gap;
    gap = slow && sample_valid && sample_ready;
    if (reset)
      pend_q.delete();
    else if (sample_valid && sample_ready)
      pend_q.delete(0);
    if (!reset && !gap && pend_q.size() > 0) begin
      sample_valid <= 1'b1;
      sample_in <= pend_q[0];
    end else begin
      sample_valid <= 1'b0;
      sample_in <= ~sample_in;
    end
  end
endmodule

/* fmd_fir_top_bench.sv */
// Self-checking bench for the FIR datapath top
`timescale 1ns/1ps
module fmd_fir_top_bench;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic er;
  } fmd_row_t;
  logic core_clk, reset, psel, penable, pwrite, slow, e, skip;
  logic [7:0] paddr;
  logic [31:0] pwdata, r;
  wire [31:0] prdata;
  wire pready, pslverr, sample_valid, sample_ready, result_valid;
  wire [17:0] sample_in;
  wire [38:0] result_out;
  int fail_count, tests_run, cyc;
  int tq[$];
  logic signed [17:0] h[8], hx[8];
  logic [38:0] exq[$], last;
  logic [5:0] ctl;
  logic [17:0] xs[10] = '{18'h1ffff, 18'h20000, 18'h00001, 18'h3ff00,
    18'h00155, 18'h20000, 18'h1ffff, 18'h3ffff, 18'h00100, 18'h2aaaa};
  logic [17:0] cv[8] = '{18'h1ffff, 18'h20000, 18'h00003, 18'h3fffb,
    18'h00107, 18'h1ffff, 18'h20000, 18'h3ff01};
  logic [5:0] cfgs[7] = '{6'h00, 6'h01, 6'h1c, 6'h08, 6'h10, 6'h3d, 6'h1f};
  fmd_row_t rows[6] = '{
    '{0, 8'h00, 0, 32'h1d, 0},
    '{1, 8'h10, 32'h1, 0, 1},
    '{0, 8'h14, 0, 0, 1},
    '{1, 8'h22, 32'h5, 0, 1},
    '{0, 8'h20, 0, 32'h1ffff, 0},
    '{1, 8'h40, 32'h1, 0, 1}};

  fmd_fir_top fmd_fir_top_inst (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .result_out(result_out), .result_valid(result_valid)
  );
  fmd_sample_src fmd_sample_src_inst (
    .core_clk(core_clk), .reset(reset), .sample_ready(sample_ready),
    .slow(slow), .sample_in(sample_in), .sample_valid(sample_valid)
  );

  function automatic logic signed [17:0] nar(input logic [17:0] v);
    return ctl[5] ? {{9{v[8]}}, v[8:0]} : v;
  endfunction

  // Take-to-valid edges; each enabled stage adds one
  function automatic int lat();
    if (ctl[1])
      return ctl[3] + ctl[4] + 3;
    return (ctl[0] | ctl[2]) + ctl[3] + ctl[4] + 1;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [38:0] s, input logic [38:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
    end
  endtask

  // One APB transfer; pready is waited for under a bound
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setc(input int i, input logic [17:0] v);
    h[i] = nar(v);
    apb(1, 8'h20 + 8'(4 * i), {{14{v[17]}}, v}, r, e);
    apb(0, 8'h20 + 8'(4 * i), 0, r, e);
    chk(r, {{14{h[i][17]}}, h[i]});
  endtask

  task automatic drain;
    int n;
    n = 0;
    while ((exq.size() > 0 || fmd_sample_src_inst.pend_q.size() > 0)
      && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500) begin
      fail_count++;
      test_done;
    end
  endtask

  // Mode switch, stale stage tags run out, then zeros flush the line;
  // results in that window go unchecked
  task automatic cfg(input logic [5:0] c);
    apb(1, 8'h00, {26'h0, c}, r, e);
    ctl = c;
    skip = 1;
    repeat (8) @(posedge core_clk);
    repeat (8) fmd_sample_src_inst.push(18'h0);
    drain;
    skip = 0;
  endtask

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  // Reference delay line of taken samples and the expected results
  always @(posedge core_clk) begin
    logic signed [38:0] y;
    int d;
    cyc++;
    if (reset) begin
      exq.delete();
      tq.delete();
      foreach (hx[i]) hx[i] = 0;
    end else begin
      if (sample_valid && sample_ready) begin
        for (int i = 7; i > 0; i--) hx[i] = hx[i-1];
        hx[0] = nar(sample_in);
        y = 0;
        foreach (hx[i]) y += hx[i] * h[i];
        exq.push_back(y);
        tq.push_back(cyc);
      end
      if (result_valid) begin
        d = lat();
        // TDM repeats the unchanged line; only a due result takes a sample
        if (tq.size() > 0 && (!ctl[1] || cyc - tq[0] >= lat())) begin
          last = exq.pop_front();
          d = cyc - tq.pop_front();
        end
        if (!skip) chk(result_out, last);
        if (!skip) chk(d, lat());
      end
    end
  end

  initial begin
    reset = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    slow = 0;
    skip = 0;
    ctl = 6'h1d;
    repeat (8) @(posedge core_clk);
    reset <= 0;
    for (int i = 0; i < 8; i++) setc(i, cv[i]);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      chk(e, rows[i].er);
      if (!rows[i].w) chk(r, rows[i].rd);
    end
    // Serial default stream at full-scale values
    foreach (xs[j]) fmd_sample_src_inst.push(xs[j]);
    drain;
    apb(0, 8'h08, 0, r, e);
    chk(r, last[31:0]);
    apb(0, 8'h0c, 0, r, e);
    chk(r, {{25{last[38]}}, last[38:32]});
    apb(0, 8'h04, 0, r, e);
    chk(r, 32'h000a0001);
    // No stage, each single stage and all three, narrow and tdm, with coefficients changed between
    foreach (cfgs[i]) begin
      cfg(cfgs[i]);
      if (cfgs[i][5])
        setc(2, 18'h0fe01);
      else
        setc(i, ~cv[i]);
      slow <= i[0];
      foreach (xs[j]) fmd_sample_src_inst.push(xs[j]);
      drain;
    end
    // Reset in mid-stream clears outputs and returns control to its 6'h1d default
    cfg(6'h1d);
    foreach (xs[j]) fmd_sample_src_inst.push(xs[j]);
    repeat (5) @(posedge core_clk);
    reset <= 1;
    repeat (2) @(posedge core_clk);
    chk(result_valid, 0);
    chk(result_out, 0);
    reset <= 0;
    apb(0, 8'h00, 0, r, e);
    chk(r, 32'h1d);
    test_done;
  end
endmodule
